//--- rtl/rtcm_pkg.sv
// constants and carrier types for the two-wire bus master
// assumes a 100 MHz system clock and a free-running link clock
// How it works
// - idle leaves both lines released so they rest high
// - start is data falling while clock high, opening a transaction
// - repeated start uses the same shape and begins a new address
// - stop is data rising while clock high, ending the transaction
// - data changes only with clock low; sampled while clock high
// - bytes are eight bits, msb first, any count per transaction; master moves 1 to 15 data bytes
// - after eighth bit transmitter releases, receiver pulls low
// - master ends read with no acknowledge then issues stop
// - a missing device acknowledge is reported as an error
// - address byte is a3 for read and a2 for write
// - write is start, address, pointer byte, data bytes, stop; master omits the pointer byte on writes with ptr_set clear
// - master refuses pointer-set bursts that cover register addresses 49 or 4a
package rtcm_pkg;
    localparam logic [7:0] RTCM_ADDR_WR = 8'ha2;
    localparam logic [7:0] RTCM_ADDR_RD = 8'ha3;
    localparam logic [7:0] RTCM_TEST_A = 8'h49;
    localparam logic [7:0] RTCM_TEST_B = 8'h4a;
    localparam int RTCM_LEN_W = 4;
    localparam logic [2:0] RTCM_BIT_LAST = 3'h7;
    // quarter bit period in link clocks
    localparam logic [3:0] RTCM_QTR = 4'h4;

    typedef struct packed {
        logic rd;
        logic ptr_set;
        logic [7:0] ptr;
        logic [3:0] len;
    } rtcm_cmd_t;

    typedef struct packed {
        logic done;
        logic nack_err;
        logic refused;
    } rtcm_sts_t;
endpackage

//--- rtl/rtcm_master.sv
// two-wire bus master that drives the clock chip's register pointer
// assumes command and data on ref_clk_in, bus timing on link_clk_in
`timescale 1ns/1ps
module rtcm_master (
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic link_clk_in,
    input wire logic link_rst_b_in,
    input wire logic cmd_valid_in,
    input wire rtcm_pkg::rtcm_cmd_t cmd_in,
    input wire logic [7:0] wr_data_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic cmd_ready_out,
    output logic wr_take_out,
    output logic rd_valid_out,
    output logic [7:0] rd_data_out,
    output rtcm_pkg::rtcm_sts_t sts_out,
    output logic scl_out,
    output logic scl_oe_out,
    output logic sda_out,
    output logic sda_oe_out
);
    import rtcm_pkg::*;

    typedef enum {
        ST_IDLE, ST_START, ST_BIT, ST_ACK, ST_STOP
    } rtcm_state_t;

    // any address of the burst reserved; the pointer wraps past ff
    function automatic logic in_test(input logic [7:0] a,
            input logic [3:0] n);
        return (8'(RTCM_TEST_A - a) < {4'h0, n})
            || (8'(RTCM_TEST_B - a) < {4'h0, n});
    endfunction

    ////////////////////////////////////////////////////////////////////
    // system side: command handshake toggles into link domain
    logic busy, req_tgl, next_busy, next_req_tgl;
    rtcm_cmd_t cmd_q, next_cmd_q;
    logic [7:0] wdat_q, next_wdat_q;
    logic [2:0] ack_s, ev_s, tk_s;
    logic ack_tgl, ev_tgl, tk_tgl;
    logic rdv, wtk, next_rdv, next_wtk;
    logic [7:0] rdd, next_rdd;
    rtcm_sts_t sts, next_sts;
    logic [7:0] lk_rbyte;
    logic lk_nack;

    always_comb begin
        next_busy = busy;
        next_req_tgl = req_tgl;
        next_cmd_q = cmd_q;
        next_wdat_q = wdat_q;
        next_rdv = 1'b0;
        next_wtk = 1'b0;
        next_rdd = rdd;
        next_sts = '{default: 1'b0};
        if (!busy && cmd_valid_in) begin
            // pointer-set bursts over test-mode addresses are refused
            if (cmd_in.len == '0 || (cmd_in.ptr_set
                    && in_test(cmd_in.ptr, cmd_in.len))) begin
                next_sts.refused = 1'b1;
            end else begin
                next_busy = 1'b1;
                next_cmd_q = cmd_in;
                next_wdat_q = wr_data_in;
                next_req_tgl = ~req_tgl;
            end
        end
        if (tk_s[2] ^ tk_s[1]) begin
            // word consumed by link; next one latched now
            next_wtk = 1'b1;
            next_wdat_q = wr_data_in;
        end
        if (ev_s[2] ^ ev_s[1]) begin
            next_rdv = 1'b1;
            next_rdd = lk_rbyte;
        end
        if (ack_s[2] ^ ack_s[1]) begin
            next_busy = 1'b0;
            next_sts.done = 1'b1;
            next_sts.nack_err = lk_nack;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            busy <= 1'b0;
            req_tgl <= 1'b0;
            cmd_q <= '0;
            wdat_q <= '0;
            rdv <= 1'b0;
            wtk <= 1'b0;
            rdd <= '0;
            sts <= '0;
            ack_s <= '0;
            ev_s <= '0;
            tk_s <= '0;
        end else begin
            busy <= next_busy;
            req_tgl <= next_req_tgl;
            cmd_q <= next_cmd_q;
            wdat_q <= next_wdat_q;
            rdv <= next_rdv;
            wtk <= next_wtk;
            rdd <= next_rdd;
            sts <= next_sts;
            ack_s <= {ack_s[1:0], ack_tgl};
            ev_s <= {ev_s[1:0], ev_tgl};
            tk_s <= {tk_s[1:0], tk_tgl};
        end
    end

    assign cmd_ready_out = ~busy;
    assign wr_take_out = wtk;
    assign rd_valid_out = rdv;
    assign rd_data_out = rdd;
    assign sts_out = sts;

    ////////////////////////////////////////////////////////////////////
    // link side: bit engine on link clock
    rtcm_state_t st, next_st;
    logic [2:0] rq_s;
    logic [1:0] sda_s, scl_s;
    logic [3:0] tq, next_tq;
    logic [1:0] ph, next_ph;
    logic [2:0] bitn, next_bitn;
    logic [3:0] left, next_left;
    logic [7:0] sh, next_sh;
    logic [1:0] seg, next_seg;
    logic scl_lo, sda_lo, next_scl_lo, next_sda_lo;
    logic next_ack_tgl, next_ev_tgl, next_tk_tgl, next_nack;
    logic [7:0] next_rbyte;
    logic tick;

    // command word is stable while the handshake is outstanding
    assign tick = (tq == RTCM_QTR - 4'h1);

    // true while the device is transmitting data bytes
    function automatic logic rx_phase();
        return cmd_q.rd && seg == 2'h3;
    endfunction

    always_comb begin
        next_st = st;
        next_tq = tick ? 4'h0 : tq + 4'h1;
        next_ph = ph;
        next_bitn = bitn;
        next_left = left;
        next_sh = sh;
        next_seg = seg;
        next_scl_lo = scl_lo;
        next_sda_lo = sda_lo;
        next_ack_tgl = ack_tgl;
        next_ev_tgl = ev_tgl;
        next_tk_tgl = tk_tgl;
        next_nack = lk_nack;
        next_rbyte = lk_rbyte;
        case (st)
            ST_IDLE: begin
                next_scl_lo = 1'b0;
                next_sda_lo = 1'b0;
                if (rq_s[2] ^ rq_s[1]) begin
                    next_st = ST_START;
                    next_ph = 2'h0;
                    next_nack = 1'b0;
                    next_seg = cmd_q.ptr_set ? 2'h0 : 2'h2;
                    next_left = cmd_q.len;
                end
            end
            ST_START: if (tick) begin
                // pull data low with clock high
                next_ph = ph + 2'h1;
                case (ph)
                    2'h0: begin
                        next_scl_lo = 1'b0;
                        next_sda_lo = 1'b0;
                    end
                    2'h1: next_sda_lo = 1'b1;
                    2'h2: next_scl_lo = 1'b1;
                    default: begin
                        // address byte
                        next_sh = (seg == 2'h2 && cmd_q.rd) ?
                            RTCM_ADDR_RD : RTCM_ADDR_WR;
                        next_bitn = 3'h0;
                        next_st = ST_BIT;
                        next_ph = 2'h0;
                    end
                endcase
            end
            ST_BIT: if (tick) begin
                // drive with clock low, sample with clock high
                next_ph = ph + 2'h1;
                case (ph)
                    2'h0: next_sda_lo = rx_phase() ? 1'b0 : ~sh[7];
                    2'h1: next_scl_lo = 1'b0;
                    2'h2: begin
                        // a far end holding the clock low stretches the bit
                        if (scl_s[1]) begin
                            next_sh = {sh[6:0], sda_s[1]};
                        end else begin
                            next_ph = ph;
                        end
                    end
                    default: begin
                        next_scl_lo = 1'b1;
                        next_bitn = bitn + 3'h1;
                        if (bitn == RTCM_BIT_LAST) begin
                            next_st = ST_ACK;
                        end
                    end
                endcase
            end
            ST_ACK: if (tick) begin
                next_ph = ph + 2'h1;
                case (ph)
                    2'h0: begin
                        // master acks read bytes, last one not
                        next_sda_lo = rx_phase() && (left != 4'h1);
                        if (rx_phase()) begin
                            next_rbyte = sh;
                            next_ev_tgl = ~ev_tgl;
                        end
                    end
                    2'h1: next_scl_lo = 1'b0;
                    2'h2: begin
                        if (!rx_phase() && sda_s[1]) begin
                            next_nack = 1'b1;
                        end
                    end
                    default: begin
                        next_scl_lo = 1'b1;
                        next_ph = 2'h0;
                        next_bitn = 3'h0;
                        next_st = ST_BIT;
                        if (lk_nack) begin
                            next_st = ST_STOP;
                        end else if (seg == 2'h0) begin
                            next_sh = cmd_q.ptr; // pointer byte
                            next_seg = 2'h1;
                        end else if (seg == 2'h1 && cmd_q.rd) begin
                            next_st = ST_START; // restart
                            next_seg = 2'h2;
                        end else if (seg == 2'h1 || seg == 2'h2) begin
                            // reads consume no write word
                            next_seg = 2'h3;
                            next_sh = wdat_q;
                            if (!cmd_q.rd) begin
                                next_tk_tgl = ~tk_tgl;
                            end
                        end else if (left == 4'h1) begin
                            next_st = ST_STOP;
                        end else begin
                            next_left = left - 4'h1;
                            next_sh = wdat_q;
                            if (!cmd_q.rd) begin
                                next_tk_tgl = ~tk_tgl;
                            end
                        end
                    end
                endcase
            end
            ST_STOP: if (tick) begin
                // data low then rising with clock high
                next_ph = ph + 2'h1;
                case (ph)
                    2'h0: next_sda_lo = 1'b1;
                    2'h1: next_scl_lo = 1'b0;
                    2'h2: next_sda_lo = 1'b0;
                    default: begin
                        next_st = ST_IDLE;
                        next_ack_tgl = ~ack_tgl;
                    end
                endcase
            end
            default: next_st = ST_IDLE;
        endcase
    end

    always_ff @(posedge link_clk_in) begin
        if (!link_rst_b_in) begin
            st <= ST_IDLE;
            tq <= '0;
            ph <= '0;
            bitn <= '0;
            left <= '0;
            sh <= '0;
            seg <= '0;
            scl_lo <= 1'b0;
            sda_lo <= 1'b0;
            ack_tgl <= 1'b0;
            ev_tgl <= 1'b0;
            tk_tgl <= 1'b0;
            lk_nack <= 1'b0;
            lk_rbyte <= '0;
            rq_s <= '0;
            sda_s <= '0;
            scl_s <= '0;
        end else begin
            st <= next_st;
            tq <= next_tq;
            ph <= next_ph;
            bitn <= next_bitn;
            left <= next_left;
            sh <= next_sh;
            seg <= next_seg;
            scl_lo <= next_scl_lo;
            sda_lo <= next_sda_lo;
            ack_tgl <= next_ack_tgl;
            ev_tgl <= next_ev_tgl;
            tk_tgl <= next_tk_tgl;
            lk_nack <= next_nack;
            lk_rbyte <= next_rbyte;
            rq_s <= {rq_s[1:0], req_tgl};
            sda_s <= {sda_s[0], sda_in};
            scl_s <= {scl_s[0], scl_in};
        end
    end

    // open drain: drive low only
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe_out = scl_lo;
    assign sda_oe_out = sda_lo;
endmodule

//--- test/rtcm_master_sva.sv
// checker: command handshake and bus shape of the two-wire master
// assumes bound to rtcm_master; bus seen through its output enables
`timescale 1ns/1ps
module rtcm_master_sva
    import rtcm_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic link_clk_in,
    input wire logic link_rst_b_in,
    input wire logic cmd_valid_in,
    input wire rtcm_pkg::rtcm_cmd_t cmd_in,
    input wire logic cmd_ready_out,
    input wire rtcm_pkg::rtcm_sts_t sts_out,
    input wire logic scl_oe_out,
    input wire logic sda_oe_out
);
    logic [3:0] bitc;
    logic [3:0] next_bitc;
    logic scl_was, sda_was, take, bad, stop;
    assign take = cmd_valid_in && cmd_ready_out;
    // reserved address anywhere in the burst, pointer wrapping at ff
    assign bad = cmd_in.len == 4'h0 || cmd_in.ptr_set &&
        (8'(RTCM_TEST_A - cmd_in.ptr) < {4'h0, cmd_in.len} ||
        8'(RTCM_TEST_B - cmd_in.ptr) < {4'h0, cmd_in.len});
    assign stop = !sda_oe_out && sda_was && !scl_oe_out && !scl_was;
    ////////////////////////////////////////////////////////////////////
    // scl rises since start: 1..8 data bits, 0 on the acknowledge
    always_comb begin
        next_bitc = bitc;
        if (sda_oe_out && !sda_was && !scl_oe_out) begin
            next_bitc = 4'h0;
        end else if (scl_was && !scl_oe_out) begin
            next_bitc = (bitc == 4'h8) ? 4'h0 : bitc + 4'h1;
        end
    end
    always_ff @(posedge link_clk_in) begin
        if (!link_rst_b_in) begin
            bitc <= 4'h0;
            scl_was <= 1'b0;
            sda_was <= 1'b0;
        end else begin
            bitc <= next_bitc;
            scl_was <= scl_oe_out;
            sda_was <= sda_oe_out;
        end
    end
    ////////////////////////////////////////////////////////////////////
    property p_idle;
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        cmd_ready_out |-> !scl_oe_out && !sda_oe_out;
    endproperty
    a_idle: assert property (p_idle)
        else $error("bus driven while idle");
    property p_refuse;
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        take && bad |=> sts_out.refused;
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("reserved range not refused");
    property p_accept;
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        take && !bad |=> !sts_out.refused && !cmd_ready_out;
    endproperty
    a_accept: assert property (p_accept)
        else $error("legal command refused");
    property p_done;
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        sts_out.done |-> ##[0:2] cmd_ready_out;
    endproperty
    a_done: assert property (p_done)
        else $error("not ready after done");
    property p_start;
        @(posedge link_clk_in) disable iff (!link_rst_b_in)
        $rose(sda_oe_out) && !scl_oe_out |-> ##[1:16] scl_oe_out;
    endproperty
    a_start: assert property (p_start)
        else $error("no clock after start");
    property p_stop;
        @(posedge link_clk_in) disable iff (!link_rst_b_in)
        stop |-> (!scl_oe_out && !sda_oe_out) [*4];
    endproperty
    a_stop: assert property (p_stop)
        else $error("bus not free after stop");
    property p_stable;
        @(posedge link_clk_in) disable iff (!link_rst_b_in)
        !scl_oe_out && !scl_was && bitc >= 4'h2
            |-> $stable(sda_oe_out);
    endproperty
    a_stable: assert property (p_stable)
        else $error("data moved while clock high");
    property p_count;
        @(posedge link_clk_in) disable iff (!link_rst_b_in)
        stop |-> bitc == 4'h1;
    endproperty
    a_count: assert property (p_count)
        else $error("stop not on a byte boundary");
endmodule
bind rtcm_master rtcm_master_sva i_sva (
    .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
    .link_clk_in(link_clk_in), .link_rst_b_in(link_rst_b_in),
    .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in),
    .cmd_ready_out(cmd_ready_out), .sts_out(sts_out),
    .scl_oe_out(scl_oe_out), .sda_oe_out(sda_oe_out)
);

//--- test/rtcm_dev_model.sv
// behavioural clock chip on the two-wire bus: address, pointer, memory
// assumes pulled-up lines; it only pulls sda low, never touches scl
`timescale 1ns/1ps
module rtcm_dev_model (
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic nack_in,
    output logic sda_oe_out
);
    logic [7:0] mem [0:255];
    logic [7:0] ptr, sh;
    logic act, adr, rd, hit, need_ptr, mack;
    int bitn;
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(~i);
        end
        {sda_oe_out, act, adr, rd, hit, need_ptr, mack} = 7'h00;
        ptr = 8'h00;
        bitn = 0;
    end
    ////////////////////////////////////////////////////////////////////
    always @(negedge sda_in) begin
        if (scl_in === 1'b1) begin
            act = 1'b1;
            adr = 1'b1;
            // the clock fall right after a start opens bit 0
            bitn = -1;
        end
    end
    always @(posedge sda_in) begin
        if (scl_in === 1'b1) begin
            act = 1'b0;
        end
    end
    always @(posedge scl_in) begin
        if (act && bitn < 8 && !(rd && !adr)) begin
            sh = {sh[6:0], sda_in};
        end else if (act && bitn == 8) begin
            mack = !sda_in;
        end
    end
    // outputs change only on falling scl; open drain, pull or release
    always @(negedge scl_in) begin
        if (act) begin
            if (bitn == 7 && !(rd && !adr)) begin
                if (adr) begin
                    hit = sh[7:1] == 7'h51 && !nack_in;
                    rd = sh[0];
                    need_ptr = !sh[0];
                end else if (need_ptr) begin
                    ptr = sh;
                    need_ptr = 1'b0;
                end else begin
                    mem[ptr] = sh;
                    ptr = ptr + 8'h01;
                end
                sda_oe_out = hit;
                act = hit;
            end else if (bitn == 8) begin
                sda_oe_out = 1'b0;
                if (rd && (adr || mack)) begin
                    sh = mem[ptr];
                    ptr = ptr + 8'h01;
                    sda_oe_out = !sh[7];
                end else if (rd) begin
                    act = 1'b0;
                end
                adr = 1'b0;
            end else if (rd && !adr) begin
                sh = {sh[6:0], 1'b1};
                sda_oe_out = (bitn == 7) ? 1'b0 : !sh[7];
            end
            bitn = (bitn == 8) ? 0 : bitn + 1;
        end
    end
endmodule

//--- test/tb.sv
// self-checking bench: master against the behavioural clock chip
// assumes the rtl package and master; both share a pulled-up bus
`timescale 1ns/1ps
module tb;
    import rtcm_pkg::*;
    typedef struct packed {
        rtcm_cmd_t cmd;
        logic [7:0] base;
        logic bad;
    } rtcm_row_t;
    logic clk, lclk, rst_b, lrst_b, cmd_valid, nack, cmd_ready, wr_take;
    logic rd_valid, scl_oe, sda_oe, dev_oe, scl, sda;
    logic [7:0] wr_data, rd_data, exp_ptr;
    logic [7:0] exp_mem [0:255];
    rtcm_cmd_t cmd;
    rtcm_sts_t sts;
    rtcm_row_t rows [0:11];
    int errors = 0;
    int n_checks = 0;
    assign scl = !scl_oe;
    assign sda = !(sda_oe || dev_oe);
    rtcm_master i_dut (
        .ref_clk_in(clk), .rst_b_in(rst_b), .link_clk_in(lclk),
        .link_rst_b_in(lrst_b), .cmd_valid_in(cmd_valid), .cmd_in(cmd),
        .wr_data_in(wr_data), .scl_in(scl), .sda_in(sda),
        .cmd_ready_out(cmd_ready), .wr_take_out(wr_take),
        .rd_valid_out(rd_valid), .rd_data_out(rd_data), .sts_out(sts),
        .scl_out(), .scl_oe_out(scl_oe), .sda_out(), .sda_oe_out(sda_oe)
    );
    rtcm_dev_model i_dev (
        .scl_in(scl), .sda_in(sda), .nack_in(nack), .sda_oe_out(dev_oe)
    );
    ////////////////////////////////////////////////////////////////////
    task automatic chk8(input string nm, input logic [7:0] e,
        input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // one whole command; expectations come from the bench's own memory
    task automatic run(input rtcm_row_t r, input logic nk);
        int k, nb, t;
        logic [7:0] p;
        logic busy, ne;
        // next word is presented ahead: the take edge latches it
        k = 1;
        nb = 0;
        busy = 1'b0;
        ne = 1'b0;
        p = r.cmd.ptr_set ? r.cmd.ptr : exp_ptr;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd <= r.cmd;
        wr_data <= r.base;
        @(negedge clk);
        while (cmd_ready !== 1'b1) @(negedge clk);
        @(posedge clk);
        cmd_valid <= 1'b0;
        for (t = 0; t < 20000; t++) begin
            @(negedge clk);
            busy |= scl_oe;
            ne |= sts.nack_err;
            if (rd_valid === 1'b1) begin
                chk8("rd_data", exp_mem[p + 8'(nb)], rd_data);
                nb++;
            end
            k += int'(wr_take === 1'b1);
            if (sts.done === 1'b1 || sts.refused === 1'b1) break;
            @(posedge clk);
            wr_data <= r.base + 8'(k);
        end
        chk1("finished", 1'b1, sts.done | sts.refused);
        chk1("refused", r.bad, sts.refused);
        chk1("nack_err", nk, ne);
        chk1("bus_used", !r.bad, busy);
        if (!r.bad && !nk) begin
            chk8("rd_count", r.cmd.rd ? 8'(r.cmd.len) : 8'h00, 8'(nb));
            chk8("wr_takes", r.cmd.rd ? 8'h00 : 8'(r.cmd.len), 8'(k - 1));
            for (k = 0; k < int'(r.cmd.len); k++) begin
                if (!r.cmd.rd) exp_mem[p + 8'(k)] = r.base + 8'(k);
                chk8("dev_mem", exp_mem[p + 8'(k)], i_dev.mem[p + 8'(k)]);
            end
            exp_ptr = p + 8'(r.cmd.len);
        end
        $display("test end rd=%0b ptr=%h len=%0d", r.cmd.rd, p, r.cmd.len);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        lclk = 1'b0;
        #3;
        forever #6 lclk = ~lclk;
    end
    // about 10k cycles expected; generous margin
    initial begin
        #900000;
        errors++;
        stop_test();
    end
    initial begin
        {rst_b, lrst_b, cmd_valid, nack, wr_data, exp_ptr} = '0;
        cmd = '0;
        for (int i = 0; i < 256; i++) begin
            exp_mem[i] = 8'(~i);
        end
        rows = '{{1'b0, 1'b1, 8'h10, 4'h1, 8'h11, 1'b0},
            {1'b0, 1'b1, 8'h20, 4'h3, 8'h30, 1'b0},
            {1'b1, 1'b1, 8'h20, 4'h3, 8'h00, 1'b0},
            {1'b1, 1'b0, 8'h00, 4'h2, 8'h00, 1'b0},
            {1'b0, 1'b1, 8'hfe, 4'h3, 8'ha0, 1'b0},
            {1'b1, 1'b1, 8'hfe, 4'h3, 8'h00, 1'b0},
            {1'b1, 1'b1, 8'h50, 4'hf, 8'h00, 1'b0},
            {1'b0, 1'b1, 8'h30, 4'h0, 8'h00, 1'b1},
            {1'b0, 1'b1, 8'h49, 4'h1, 8'h00, 1'b1},
            {1'b1, 1'b1, 8'h47, 4'h3, 8'h00, 1'b1},
            {1'b0, 1'b1, 8'h4a, 4'h2, 8'h00, 1'b1},
            {1'b0, 1'b1, 8'h48, 4'h4, 8'h00, 1'b1}};
        repeat (10) @(negedge clk);
        chk1("oe_in_reset", 1'b0, scl_oe | sda_oe);
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        lrst_b <= 1'b1;
        repeat (3) @(negedge clk);
        chk1("ready_after_reset", 1'b1, cmd_ready);
        foreach (rows[i]) begin
            run(rows[i], 1'b0);
        end
        @(posedge clk);
        nack <= 1'b1;
        run(rows[0], 1'b1);
        @(posedge clk);
        nack <= 1'b0;
        run(rows[3], 1'b0);
        // second reset between commands; bus stays released
        @(posedge clk);
        rst_b <= 1'b0;
        lrst_b <= 1'b0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        lrst_b <= 1'b1;
        repeat (3) @(negedge clk);
        chk1("ready_after_reset2", 1'b1, cmd_ready);
        chk1("oe_after_reset2", 1'b0, scl_oe | sda_oe);
        $display("test end second reset");
        run(rows[2], 1'b0);
        stop_test();
    end
endmodule
